// *** dv/ir_beacon_id_timing_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
  end
module ir_beacon_id_timing_tb_top;
  import beacon_pkg::*;
  localparam int unsigned P  = 20;
  localparam int unsigned DD = 30;
  localparam int          FRZ = 5;
  logic             i_clk  = 1'b0;
  logic             i_srst = 1'b1;
  logic [2:0]       strap  = 3'h7;
  logic             blue   = 1'b0;
  logic             start  = 1'b0;
  logic             we     = 1'b0;
  logic             ce     = 1'b1;
  logic [SET_W-1:0] setv   = 8'h00;
  logic             led, busy, dv, ir;
  logic [NUM_W-1:0] num, dnum;
  logic [31:0]      rs     = 32'h3929;
  int               miscompares = 0;
  int               total_checks = 0;
  int               len;
  int               frz_at = -1;

  // short counts keep the run small
  ir_beacon_id_timing #(.PERIOD_CYCLES(P), .DEFAULT_DELAY(DD)) uut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_identity_strap_pins(strap),
    .i_blue_variant(blue), .i_emit_start(start), .i_ir_seen(ir),
    .i_set_prepause_we(we), .i_set_prepause_delay(setv), .o_led_on(led),
    .o_emit_busy(busy), .o_beacon_num(num), .o_detect_valid(dv), .o_detect_num(dnum));
  ir_light_path lp (.i_clk(i_clk), .i_led_on(led), .o_ir_seen(ir));

  initial forever #25 i_clk = ~i_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [3:0] exp_num(input logic [2:0] s, input logic b);
    return b ? {1'b0, s} + 4'h8 : ((s == 3'h0) ? 4'h8 : {1'b0, s});
  endfunction
  // low samples taken at d+2, d+2+P, ... before the pause ends
  function automatic int det_cnt(input int n, input int d);
    int c;
    c = (n * P > d + 2) ? (n * P - d + P - 3) / P : 0;
    return (c > 15) ? 15 : c;
  endfunction

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // start one pause; optionally swap straps mid pause
  task automatic emit(output int l, input int chg_at, input logic [2:0] chg);
    int i;
    @(posedge i_clk) start <= 1'b1;
    @(posedge i_clk) start <= 1'b0;
    #1;
    for (i = 0; i < 400 && led !== 1'b1; i++)
    begin
      @(posedge i_clk);
      if (i == chg_at)
        strap <= chg;
      // enable low for FRZ cycles from frz_at; the whole pause must stretch by as much
      ce <= (frz_at < 0) || (i < frz_at) || (i >= frz_at + FRZ);
      #1;
    end
    l = i;
    if (led !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic trip(input logic [2:0] s, input logic b, input int d);
    int i;
    @(posedge i_clk);
    strap <= s;
    blue  <= b;
    settle(2);
    emit(len, -1, 3'h0);
    `CHK(len, exp_num(s, b) * P + ((frz_at < 0) ? 0 : FRZ))
    for (i = 0; i < 600 && dv !== 1'b1; i++)
      settle(1);
    if (dv !== 1'b1)
    begin
      miscompares++;
      finish_test();
    end
    `CHK(dnum, 4'(det_cnt(exp_num(s, b), d)))
    settle(2);
  endtask
  task automatic set_delay(input logic [7:0] v);
    @(posedge i_clk);
    we   <= 1'b1;
    setv <= v;
    @(posedge i_clk);
    we <= 1'b0;
    settle(1);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    settle(2);
    trip(3'h4, 1'b0, DD);
    $display("test default_delay done");
    for (int i = 0; i < 48; i++)
    begin
      rs = xs(rs);
      @(posedge i_clk);
      if (i < 16)
        {blue, strap} <= 4'(i);
      else
        {blue, strap} <= rs[3:0];
      settle(2);
      `CHK(num, exp_num(strap, blue))
    end
    $display("test strap_map done");
    set_delay(8'h00);
    for (int i = 0; i < 8; i++)
    begin
      rs = xs(rs);
      trip(rs[2:0], rs[3], 0);
    end
    set_delay(8'h01);
    trip(3'h0, 1'b0, 40);
    trip(3'h7, 1'b1, 40);
    $display("test prepause_setting done");
    // freeze during the wait: emitter and receiver both slip, the count stays
    frz_at = 10;
    trip(3'h5, 1'b1, 40);
    frz_at = -1;
    $display("test clock_enable done");
    @(posedge i_clk);
    strap <= 3'h0;
    blue  <= 1'b0;
    settle(2);
    // a number below the steps done ends the pause at the close of the running period
    emit(len, 50, 3'h1);
    `CHK(len, (50 / P + 1) * P)
    $display("test strap_change done");
    finish_test();
  end
endmodule

// *** dv/ir_light_path.sv ***
`timescale 1ns/100ps
// optical path from emitter to detector, a few cycles of lag
module ir_light_path
#(
  parameter int unsigned LAT = 3
)
(
  input  wire logic i_clk,
  input  wire logic i_led_on,
  output logic      o_ir_seen
);
  logic [LAT-1:0] pipe_r;

  // lag models detector response, so sampling is not aligned to the emitter edge
  always_ff @(posedge i_clk)
  begin
    pipe_r <= {pipe_r[LAT-2:0], i_led_on};
  end
  assign o_ir_seen = pipe_r[LAT-1];
endmodule

// *** hw/beacon_pkg.sv ***
package beacon_pkg;
  // clock and timing figures
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned PERIOD_US        = 500;
  localparam int unsigned HALF_PERIOD_US   = 250;
  localparam int unsigned DELAY_STEP_US    = 2;
  localparam int unsigned DEFAULT_DELAY_US = 2000;
  localparam int unsigned PERIOD_CYC       = PERIOD_US * CLK_MHZ;
  localparam int unsigned DEFAULT_DELAY_CYC = DEFAULT_DELAY_US * CLK_MHZ;
  // counter widths
  localparam int unsigned CYC_W = 16;
  localparam int unsigned NUM_W = 4;
  localparam int unsigned SET_W = 8;
  localparam logic [CYC_W-1:0] DELAY_STEP_CYC = CYC_W'(DELAY_STEP_US * CLK_MHZ);
  // setting that puts the sample at mid period for an ideal emitter
  localparam logic [SET_W-1:0] IDEAL_DELAY_SETTING = SET_W'(HALF_PERIOD_US / DELAY_STEP_US);
  // identity mapping
  localparam logic [2:0]       STRAP_ZERO  = 3'h0;
  localparam logic [NUM_W-1:0] RED_ZERO_NUM = 4'h8;
  localparam logic [NUM_W-1:0] BLUE_OFFSET  = 4'h8;
  localparam logic [NUM_W-1:0] NUM_MAX      = 4'hF;
  // reset values
  localparam logic [CYC_W-1:0] CYC_RST = 16'h0000;
  localparam logic [NUM_W-1:0] NUM_RST = 4'h0;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_PAUSE = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_WAIT  = 3'b010,
    RX_COUNT = 3'b100
  } rx_state_t;
endpackage

// *** hw/ir_beacon_id_timing.sv ***
// Operation
// R01: the emitter holds its pause for 500 us per step of its beacon number.
// R02: period timing is reloaded exactly each step so error never accumulates.
// R03: an ideal emitter is read with a 250 us wait, sampling mid period.
// R04: the pre-pause setting 0..255 is doubled into a 0..510 us wait.
// R05: out of reset the pre-pause wait is a long default beyond the setting range.
// R06: the three strap pins form a binary code, first pin most significant.
// R07: a grounded strap reads 0 and an open strap reads 1 through a pull-up.
// R08: the straps are watched every cycle and a change applies at once.
// R09: red variant maps codes 1..7 to numbers 1..7 and code 0 to number 8.
// R10: blue variant number is the strap code plus eight, giving 8..15.
// R11: after the wait the receiver counts whole periods of pause and reports them.
`timescale 1ns/100ps
module ir_beacon_id_timing
#(
  parameter int unsigned PERIOD_CYCLES = beacon_pkg::PERIOD_CYC,
  parameter int unsigned DEFAULT_DELAY = beacon_pkg::DEFAULT_DELAY_CYC
)
(
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  input  wire logic                          i_ce,
  input  wire logic [2:0]                    i_identity_strap_pins,
  input  wire logic                          i_blue_variant,
  input  wire logic                          i_emit_start,
  input  wire logic                          i_ir_seen,
  input  wire logic                          i_set_prepause_we,
  input  wire logic [beacon_pkg::SET_W-1:0]  i_set_prepause_delay,
  output logic                               o_led_on,
  output logic                               o_emit_busy,
  output logic [beacon_pkg::NUM_W-1:0]       o_beacon_num,
  output logic                               o_detect_valid,
  output logic [beacon_pkg::NUM_W-1:0]       o_detect_num
);
  import beacon_pkg::*;

  localparam logic [CYC_W-1:0] PER_LAST  = CYC_W'(PERIOD_CYCLES - 1);
  localparam logic [CYC_W-1:0] DLY_RESET = CYC_W'(DEFAULT_DELAY);

  // strap code to beacon number; pins are pad inputs with pull-ups
  function automatic logic [NUM_W-1:0] beacon_num_f(input logic [2:0] pins,
                                                     input logic       blue);
    logic [NUM_W-1:0] code;
    code = {1'b0, pins}; // first pin is the msb R06
    if (blue)
      beacon_num_f = code + BLUE_OFFSET; // R10
    else if (pins == STRAP_ZERO)
      beacon_num_f = RED_ZERO_NUM; // R09
    else
      beacon_num_f = code; // R09
  endfunction

  logic [NUM_W-1:0] num_now;
  assign num_now = beacon_num_f(i_identity_strap_pins, i_blue_variant); // R08

  // emitter
  tx_state_t        tx_state_r, tx_state_nxt;
  logic [CYC_W-1:0] tx_cyc_r, tx_cyc_nxt;
  logic [NUM_W-1:0] tx_step_r, tx_step_nxt;
  logic [NUM_W-1:0] num_r, num_nxt;
  logic             tx_end;

  // pause ends on the live number, so a strap change mid pause applies at once
  assign tx_end = (tx_cyc_r == PER_LAST) && ((tx_step_r + 4'h1) >= num_r);

  // emitter next state
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tx_cyc_nxt   = tx_cyc_r;
    tx_step_nxt  = tx_step_r;
    num_nxt      = num_now; // R08
    case (tx_state_r)
      TX_IDLE:
      begin
        if (i_emit_start)
        begin
          tx_state_nxt = TX_PAUSE;
          tx_cyc_nxt   = CYC_RST;
          tx_step_nxt  = NUM_RST;
        end
      end
      TX_PAUSE:
      begin
        if (tx_end)
          tx_state_nxt = TX_IDLE; // R01
        else if (tx_cyc_r == PER_LAST)
        begin
          // exact reload, no slip per step
          tx_cyc_nxt  = CYC_RST; // R02
          tx_step_nxt = tx_step_r + 4'h1; // R01
        end
        else
          tx_cyc_nxt = tx_cyc_r + 16'h0001;
      end
      default:
        tx_state_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tx_state_r <= TX_IDLE;
      tx_cyc_r   <= CYC_RST;
      tx_step_r  <= NUM_RST;
      num_r      <= NUM_RST;
    end
    else if (i_ce)
    begin
      tx_state_r <= tx_state_nxt;
      tx_cyc_r   <= tx_cyc_nxt;
      tx_step_r  <= tx_step_nxt;
      num_r      <= num_nxt;
    end
  end

  assign o_led_on     = (tx_state_r == TX_IDLE);
  assign o_emit_busy  = (tx_state_r == TX_PAUSE);
  assign o_beacon_num = num_r;

  // receiver
  rx_state_t        rx_state_r, rx_state_nxt;
  logic [CYC_W-1:0] rx_cyc_r, rx_cyc_nxt;
  logic [CYC_W-1:0] delay_r, delay_nxt;
  logic [NUM_W-1:0] rx_cnt_r, rx_cnt_nxt;
  logic [NUM_W-1:0] det_num_r, det_num_nxt;
  logic             det_vld_r, det_vld_nxt;
  logic             ir_prev_r;

  // receiver next state
  always_comb
  begin
    rx_state_nxt = rx_state_r;
    rx_cyc_nxt   = rx_cyc_r;
    rx_cnt_nxt   = rx_cnt_r;
    det_num_nxt  = det_num_r;
    det_vld_nxt  = 1'b0;
    delay_nxt    = delay_r;
    if (i_set_prepause_we)
      delay_nxt = CYC_W'({8'h00, i_set_prepause_delay} * DELAY_STEP_CYC); // R04
    case (rx_state_r)
      RX_IDLE:
      begin
        // falling edge of the light marks the start of the pause
        if (ir_prev_r && !i_ir_seen)
        begin
          rx_state_nxt = RX_WAIT;
          rx_cyc_nxt   = delay_r; // R03
          rx_cnt_nxt   = NUM_RST;
        end
      end
      RX_WAIT:
      begin
        if (rx_cyc_r == CYC_RST)
          rx_state_nxt = RX_COUNT;
        else
          rx_cyc_nxt = rx_cyc_r - 16'h0001;
      end
      RX_COUNT:
      begin
        // one sample per period, landing where the wait placed it
        if (rx_cyc_r == CYC_RST)
        begin
          if (i_ir_seen)
          begin
            rx_state_nxt = RX_IDLE;
            det_num_nxt  = rx_cnt_r; // R11
            det_vld_nxt  = 1'b1; // R11
          end
          else if (rx_cnt_r != NUM_MAX)
            rx_cnt_nxt = rx_cnt_r + 4'h1; // R11
          if (!i_ir_seen)
            rx_cyc_nxt = PER_LAST;
        end
        else
          rx_cyc_nxt = rx_cyc_r - 16'h0001;
      end
      default:
        rx_state_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_state_r <= RX_IDLE;
      rx_cyc_r   <= CYC_RST;
      rx_cnt_r   <= NUM_RST;
      det_num_r  <= NUM_RST;
      det_vld_r  <= 1'b0;
      delay_r    <= DLY_RESET; // R05
      ir_prev_r  <= 1'b0;
    end
    else if (i_ce)
    begin
      rx_state_r <= rx_state_nxt;
      rx_cyc_r   <= rx_cyc_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      det_num_r  <= det_num_nxt;
      det_vld_r  <= det_vld_nxt;
      delay_r    <= delay_nxt;
      ir_prev_r  <= i_ir_seen;
    end
  end

  // valid would otherwise repeat for every frozen cycle
  assign o_detect_valid = det_vld_r & i_ce;
  assign o_detect_num   = det_num_r;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // strap map written from the rule table, not from the function
  red_zero_map_a: assert property ( // R09
    !i_blue_variant && (i_identity_strap_pins == 3'h0) |-> num_now == 4'h8)
    else $error("red code 0 not number 8");
  red_code_map_a: assert property ( // R06
    !i_blue_variant && (i_identity_strap_pins != 3'h0)
    |-> num_now == {1'b0, i_identity_strap_pins})
    else $error("red strap map wrong");
  blue_map_a: assert property ( // R10
    i_blue_variant |-> num_now == {1'b0, i_identity_strap_pins} + 4'h8)
    else $error("blue strap map wrong");
  // the release edge still loads the reset value, so it is left out
  strap_live_a: assert property ( // R08
    !i_srst && i_ce |=> o_beacon_num == $past(num_now))
    else $error("strap change not applied");
  pause_end_a: assert property ( // R01
    i_ce && o_emit_busy && tx_end |=> o_led_on && !o_emit_busy)
    else $error("pause did not end on step count");
  period_reload_a: assert property ( // R02
    i_ce && o_emit_busy && (tx_cyc_r == PER_LAST) && !tx_end
    |=> (tx_cyc_r == CYC_RST) && (tx_step_r == $past(tx_step_r) + 4'h1))
    else $error("period reload slipped");
  delay_scale_a: assert property ( // R04
    i_ce && i_set_prepause_we
    |=> 32'(delay_r) == 32'($past(i_set_prepause_delay)) * DELAY_STEP_US * CLK_MHZ)
    else $error("delay setting not doubled");
  default_delay_a: assert property ( // R05
    $fell(i_srst) |-> delay_r == DLY_RESET)
    else $error("default delay missing");
  wait_load_a: assert property ( // R03
    i_ce && (rx_state_r == RX_IDLE) && ir_prev_r && !i_ir_seen
    |=> (rx_state_r == RX_WAIT) && (rx_cyc_r == $past(delay_r)))
    else $error("wait not loaded");
  count_report_a: assert property ( // R11
    i_ce && (rx_state_r == RX_COUNT) && (rx_cyc_r == CYC_RST) && i_ir_seen
    |=> (o_detect_num == $past(rx_cnt_r)) && (rx_state_r == RX_IDLE))
    else $error("count not reported");
endmodule
